// *** hw/pmc_defs.svh ***
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Register indexes; byte address is four times the index
`define PMC_CTRL_ONE_IDX    16'hfff0
`define PMC_CTRL_TWO_IDX    16'hfff1
// Reset values, reserved bits read as one
`define PMC_ONE_RST         8'h07
`define PMC_TWO_RST         8'he0
`define PMC_ONE_RSVD        8'h07
`define PMC_TWO_RSVD        8'he0
// Field positions in power_ctrl_one
`define PMC_STANDBY_SEL_BIT 7
`define PMC_SETTLE_SEL_LSB  4
`define PMC_LOW_SPEED_BIT   3
// Field positions in power_ctrl_two
`define PMC_NOISE_SEL_BIT   4
`define PMC_DIRECT_BIT      3
`define PMC_MED_SPEED_BIT   2
`define PMC_SUB_DIV_LSB     0
// Settling waits in states, one state per system clock cycle
`define PMC_STATE_CYCLES    1
`define PMC_SETTLE_STATES_0 8192
`define PMC_SETTLE_STATES_1 16384
`define PMC_SETTLE_STATES_2 32768
`define PMC_SETTLE_STATES_3 65536
`define PMC_SETTLE_STATES_4 131072
// Medium speed divider and noise sampling divisors
`define PMC_MED_DIV         8
`define PMC_NOISE_DIV_SLOW  4'hf
`define PMC_NOISE_DIV_FAST  2'h3
// Wake sources: 0 timer a, 1 timer f, 2 timer g, 3..7 irq, 8..15 wakeup pins,
// 16 serial one, 17 serial three, 18 converter
`define PMC_WAKE_W          19
`define PMC_IRQ_LSB         3
`define PMC_MASK_SLEEP      19'h7ffff
`define PMC_MASK_STANDBY    19'h0ff18
`define PMC_MASK_WATCH      19'h0ff09
`define PMC_MASK_SUBSLEEP   19'h0fffd
`endif

// *** hw/pmc_pkg.sv ***
package pmc_pkg;
  // Operating modes, one-hot
  typedef enum logic [7:0] {
    PMC_HIGH     = 8'h01,
    PMC_MED      = 8'h02,
    PMC_SUB      = 8'h04,
    PMC_SLEEP    = 8'h08,
    PMC_SUBSLEEP = 8'h10,
    PMC_WATCH    = 8'h20,
    PMC_STANDBY  = 8'h40,
    PMC_SETTLE   = 8'h80
  } pmc_mode_type;
endpackage

// *** hw/pmc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_top #(
  parameter int unsigned ADDR_W       = 18,
  parameter logic [3:0]  MED_DIV      = 4'(`PMC_MED_DIV),
  parameter logic [17:0] SETTLE_CNT_0 = 18'(`PMC_SETTLE_STATES_0 * `PMC_STATE_CYCLES),
  parameter logic [17:0] SETTLE_CNT_1 = 18'(`PMC_SETTLE_STATES_1 * `PMC_STATE_CYCLES),
  parameter logic [17:0] SETTLE_CNT_2 = 18'(`PMC_SETTLE_STATES_2 * `PMC_STATE_CYCLES),
  parameter logic [17:0] SETTLE_CNT_3 = 18'(`PMC_SETTLE_STATES_3 * `PMC_STATE_CYCLES),
  parameter logic [17:0] SETTLE_CNT_4 = 18'(`PMC_SETTLE_STATES_4 * `PMC_STATE_CYCLES)
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [ADDR_W-1:0]        paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic                     sleep_exec_i,
  input  wire logic                     timer_a_clock_source_bit_i,
  input  wire logic                     irq_mask_i,
  input  wire logic [`PMC_WAKE_W-1:0]   wake_req_i,
  input  wire logic [`PMC_WAKE_W-1:0]   wake_en_i,
  input  wire logic                     sub_tick_i,
  input  wire logic                     external_reset_n_i,
  output var pmc_pkg::pmc_mode_type     mode_o,
  output logic                          cpu_clk_en_o,
  output logic                          periph_clk_en_o,
  output logic                          sys_osc_en_o,
  output logic                          noise_sample_en_o,
  output logic                          port_hiz_o,
  output logic [4:0]                    irq_ignore_o,
  output logic                          wake_exec_o,
  output logic                          cpu_reset_o
);
  import pmc_pkg::*;

  localparam int unsigned IW = ADDR_W - 2;

  pmc_mode_type       mode_q, mode_d, sleep_tgt, tgt_q;
  logic [7:0]         one_q, two_q;
  logic [31:0]        prdata_q;
  logic [17:0]        settle_cnt_q, settle_len_q, settle_obs_q;
  logic [3:0]         med_cnt_q, noise_cnt_q;
  logic [2:0]         sub_cnt_q, sub_mask;
  logic [4:0]         irq_ignore_q;
  logic [`PMC_WAKE_W-1:0] cur_mask;
  logic               ext_rst_meta_q, ext_rst_sync_q;
  logic               hit_one, hit_two, wr_en, pending, wake_exec_d;
  logic               wake_exec_q, cpu_clk_en_q, periph_clk_en_q, sys_osc_en_q;
  logic               noise_en_q, port_hiz_q;
  logic               standby_select, low_speed_select, noise_sample_rate_select, direct_transfer_enable, medium_speed_select, timer_a_clock_source_bit, act;

  // Control bit views
  assign standby_select  = one_q[`PMC_STANDBY_SEL_BIT];
  assign low_speed_select  = one_q[`PMC_LOW_SPEED_BIT];
  assign noise_sample_rate_select = two_q[`PMC_NOISE_SEL_BIT];
  assign direct_transfer_enable  = two_q[`PMC_DIRECT_BIT];
  assign medium_speed_select  = two_q[`PMC_MED_SPEED_BIT];
  assign timer_a_clock_source_bit  = timer_a_clock_source_bit_i;
  assign act   = (mode_q == PMC_HIGH) || (mode_q == PMC_MED);

  // Reset pin synchroniser, idle high
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_rst_meta_q <= 1'b1;
      ext_rst_sync_q <= 1'b1;
    end else begin
      ext_rst_meta_q <= external_reset_n_i;
      ext_rst_sync_q <= ext_rst_meta_q;
    end
  end

  assign cpu_reset_o = ~ext_rst_sync_q;

  // APB decode, word aligned only
  assign hit_one   = (paddr_i[1:0] == 2'h0) && (paddr_i[ADDR_W-1:2] == IW'(`PMC_CTRL_ONE_IDX));
  assign hit_two   = (paddr_i[1:0] == 2'h0) && (paddr_i[ADDR_W-1:2] == IW'(`PMC_CTRL_TWO_IDX));
  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(hit_one || hit_two);
  assign prdata_o  = prdata_q;

  // Read data captured in setup, so it is steady through access
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_q <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= hit_one ? {24'h0, one_q} : (hit_two ? {24'h0, two_q} : 32'h0);
    end
  end

  // First control register; reserved bits forced to one
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      one_q <= `PMC_ONE_RST;
    end else if (!ext_rst_sync_q) begin
      one_q <= `PMC_ONE_RST;
    end else if (wr_en && hit_one) begin
      one_q <= pwdata_i[7:0] | `PMC_ONE_RSVD;
    end
  end

  // Second control register; divider frozen while it drives the cpu
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      two_q <= `PMC_TWO_RST;
    end else if (!ext_rst_sync_q) begin
      two_q <= `PMC_TWO_RST;
    end else if (wr_en && hit_two) begin
      two_q <= pwdata_i[7:0] | `PMC_TWO_RSVD;
      if (mode_q == PMC_SUB) begin
        two_q[`PMC_SUB_DIV_LSB +: 2] <= two_q[`PMC_SUB_DIV_LSB +: 2];
      end
    end
  end

  // Settle length from the three-bit select
  function automatic logic [17:0] settle_len(input logic [2:0] sel);
    logic [17:0] len;
    len = SETTLE_CNT_4;
    if (!sel[2]) begin
      unique case (sel[1:0])
        2'h0: len = SETTLE_CNT_0;
        2'h1: len = SETTLE_CNT_1;
        2'h2: len = SETTLE_CNT_2;
        2'h3: len = SETTLE_CNT_3;
      endcase
    end
    return len;
  endfunction

  // Target of a power-down instruction, decided once from current bits
  always_comb begin
    sleep_tgt = mode_q;
    if (act) begin
      if (direct_transfer_enable && standby_select && timer_a_clock_source_bit && low_speed_select) begin
        sleep_tgt = PMC_SUB;
      end else if (direct_transfer_enable && mode_q == PMC_HIGH && !standby_select && medium_speed_select && !low_speed_select) begin
        sleep_tgt = PMC_MED;
      end else if (direct_transfer_enable && mode_q == PMC_MED && !standby_select && !medium_speed_select && !low_speed_select) begin
        sleep_tgt = PMC_HIGH;
      end else if (!standby_select && !low_speed_select) begin
        sleep_tgt = PMC_SLEEP;
      end else if (standby_select && timer_a_clock_source_bit) begin
        sleep_tgt = PMC_WATCH;
      end else if (standby_select && !low_speed_select) begin
        sleep_tgt = PMC_STANDBY;
      end
    end else if (mode_q == PMC_SUB) begin
      if (direct_transfer_enable && standby_select && timer_a_clock_source_bit && !low_speed_select) begin
        sleep_tgt = medium_speed_select ? PMC_MED : PMC_HIGH;
      end else if (standby_select && timer_a_clock_source_bit) begin
        sleep_tgt = PMC_WATCH;
      end else if (!standby_select) begin
        sleep_tgt = PMC_SUBSLEEP;
      end
    end
  end

  // Wake sources allowed in the present mode
  always_comb begin
    unique case (mode_q)
      PMC_SLEEP:    cur_mask = `PMC_MASK_SLEEP;
      PMC_STANDBY:  cur_mask = `PMC_MASK_STANDBY;
      PMC_WATCH:    cur_mask = `PMC_MASK_WATCH;
      PMC_SUBSLEEP: cur_mask = `PMC_MASK_SUBSLEEP;
      default:      cur_mask = '0;
    endcase
  end

  // Global mask and per-source enables hold the device asleep
  assign pending = (|(wake_req_i & wake_en_i & cur_mask)) && !irq_mask_i;

  // Mode sequencing
  always_comb begin
    mode_d      = mode_q;
    wake_exec_d = 1'b0;
    unique case (mode_q)
      PMC_HIGH, PMC_MED, PMC_SUB: begin
        mode_d = sleep_exec_i ? sleep_tgt : mode_q;
      end
      PMC_SLEEP: begin
        if (pending) begin
          mode_d      = medium_speed_select ? PMC_MED : PMC_HIGH;
          wake_exec_d = 1'b1;
        end
      end
      PMC_SUBSLEEP: begin
        if (pending) begin
          mode_d      = PMC_SUB;
          wake_exec_d = 1'b1;
        end
      end
      PMC_WATCH: begin
        if (pending && low_speed_select) begin
          mode_d      = PMC_SUB;
          wake_exec_d = 1'b1;
        end else if (pending) begin
          mode_d = PMC_SETTLE;
        end
      end
      PMC_STANDBY: begin
        mode_d = pending ? PMC_SETTLE : mode_q;
      end
      PMC_SETTLE: begin
        if (settle_cnt_q == 18'h0) begin
          mode_d      = tgt_q;
          wake_exec_d = 1'b1;
        end
      end
      default: mode_d = PMC_HIGH;
    endcase
  end

  // Mode register; reset pin returns to high speed
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q      <= PMC_HIGH;
      wake_exec_q <= 1'b0;
    end else if (!ext_rst_sync_q) begin
      mode_q      <= PMC_HIGH;
      wake_exec_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      wake_exec_q <= wake_exec_d;
    end
  end

  // Settle counter, loaded on entry with the selected wait less one
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_cnt_q <= 18'h0;
      settle_len_q <= 18'h0;
      tgt_q        <= PMC_HIGH;
    end else if (mode_q != PMC_SETTLE && mode_d == PMC_SETTLE) begin
      settle_len_q <= settle_len(one_q[`PMC_SETTLE_SEL_LSB +: 3]);
      settle_cnt_q <= settle_len(one_q[`PMC_SETTLE_SEL_LSB +: 3]) - 18'h1;
      tgt_q        <= medium_speed_select ? PMC_MED : PMC_HIGH;
    end else if (mode_q == PMC_SETTLE && settle_cnt_q != 18'h0) begin
      settle_cnt_q <= settle_cnt_q - 18'h1;
    end
  end

  // Clock dividers for medium speed, subactive and noise sampling
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      med_cnt_q   <= 4'h0;
      sub_cnt_q   <= 3'h0;
      noise_cnt_q <= 4'h0;
    end else begin
      med_cnt_q   <= (med_cnt_q == MED_DIV - 4'h1) ? 4'h0 : med_cnt_q + 4'h1;
      noise_cnt_q <= noise_cnt_q + 4'h1;
      if (sub_tick_i) begin
        sub_cnt_q <= sub_cnt_q + 3'h1;
      end
    end
  end

  // Divide by 8, 4 or 2 of the watch clock
  always_comb begin
    unique casez (two_q[`PMC_SUB_DIV_LSB +: 2])
      2'b00:   sub_mask = 3'h7;
      2'b01:   sub_mask = 3'h3;
      2'b1?:   sub_mask = 3'h1;
    endcase
  end

  // Clock and pin controls follow the next mode, so they line up with it
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_clk_en_q    <= 1'b0;
      periph_clk_en_q <= 1'b0;
      sys_osc_en_q    <= 1'b1;
      port_hiz_q      <= 1'b0;
      irq_ignore_q    <= 5'h0;
    end else begin
      unique case (mode_d)
        PMC_HIGH: cpu_clk_en_q <= 1'b1;
        PMC_MED:  cpu_clk_en_q <= (med_cnt_q == MED_DIV - 4'h1);
        PMC_SUB:  cpu_clk_en_q <= sub_tick_i && ((sub_cnt_q & sub_mask) == sub_mask);
        default:  cpu_clk_en_q <= 1'b0;
      endcase
      periph_clk_en_q <= (mode_d == PMC_HIGH) || (mode_d == PMC_MED) || (mode_d == PMC_SLEEP);
      sys_osc_en_q    <= (mode_d == PMC_HIGH) || (mode_d == PMC_MED) || (mode_d == PMC_SLEEP) ||
                         (mode_d == PMC_SETTLE);
      port_hiz_q      <= (mode_d == PMC_STANDBY);
      if (mode_d == PMC_WATCH) begin
        irq_ignore_q <= ~5'(`PMC_MASK_WATCH >> `PMC_IRQ_LSB);
      end else if (mode_d == PMC_STANDBY) begin
        irq_ignore_q <= ~5'(`PMC_MASK_STANDBY >> `PMC_IRQ_LSB);
      end else begin
        irq_ignore_q <= 5'h0;
      end
    end
  end

  // Noise sample strobe; only meaningful while the oscillator runs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      noise_en_q <= 1'b0;
    end else begin
      noise_en_q <= sys_osc_en_q && (noise_sample_rate_select ? (noise_cnt_q[1:0] == `PMC_NOISE_DIV_FAST) :
                                              (noise_cnt_q == `PMC_NOISE_DIV_SLOW));
    end
  end

  assign mode_o            = mode_q;
  assign cpu_clk_en_o      = cpu_clk_en_q;
  assign periph_clk_en_o   = periph_clk_en_q;
  assign sys_osc_en_o      = sys_osc_en_q;
  assign noise_sample_en_o = noise_en_q;
  assign port_hiz_o        = port_hiz_q;
  assign irq_ignore_o      = irq_ignore_q;
  assign wake_exec_o       = wake_exec_q;

  // Cycles spent settling, seen only by the checks below
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_obs_q <= 18'h0;
    end else begin
      settle_obs_q <= (mode_q == PMC_SETTLE) ? settle_obs_q + 18'h1 : 18'h0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i || !ext_rst_sync_q);

  sleep_entry_a: assert property (act && sleep_exec_i && !standby_select && !low_speed_select && !direct_transfer_enable |=> mode_q == PMC_SLEEP)
    else $error("power-down did not enter sleep");
  standby_entry_a: assert property (act && sleep_exec_i && standby_select && !low_speed_select && !timer_a_clock_source_bit |=> mode_q == PMC_STANDBY)
    else $error("power-down did not enter standby");
  watch_entry_a: assert property ((act || mode_q == PMC_SUB) && sleep_exec_i && standby_select && timer_a_clock_source_bit && !direct_transfer_enable
                                  |=> mode_q == PMC_WATCH)
    else $error("power-down did not enter watch");
  direct_med_a: assert property (mode_q == PMC_HIGH && sleep_exec_i && direct_transfer_enable && !standby_select && medium_speed_select && !low_speed_select
                                 |=> mode_q == PMC_MED ##1 mode_q == PMC_MED)
    else $error("direct transfer to medium speed failed");
  sub_to_active_a: assert property (mode_q == PMC_SUB && sleep_exec_i && direct_transfer_enable && standby_select && timer_a_clock_source_bit && !low_speed_select
                                    |=> mode_q == ($past(medium_speed_select) ? PMC_MED : PMC_HIGH) && !wake_exec_o)
    else $error("direct transfer from subactive wrong");
  rsvd_read_a: assert property (psel_i && penable_i && !pwrite_i && hit_one |-> prdata_o[2:0] == 3'h7)
    else $error("reserved bits not read as one");
  div_lock_a: assert property (mode_q == PMC_SUB |=> two_q[1:0] == $past(two_q[1:0]))
    else $error("divider changed in subactive");
  sleep_wake_a: assert property (mode_q == PMC_SLEEP && pending
                                 |=> wake_exec_o && mode_q == ($past(medium_speed_select) ? PMC_MED : PMC_HIGH))
    else $error("sleep wake did not resume correctly");
  sleep_hold_a: assert property (mode_q == PMC_SLEEP && irq_mask_i |=> mode_q == PMC_SLEEP)
    else $error("masked interrupt left sleep");
  cpu_stop_a: assert property (mode_q == PMC_SLEEP |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("clocks wrong in sleep");
  settle_len_a: assert property (mode_q == PMC_SETTLE && mode_d != PMC_SETTLE
                                 |-> settle_obs_q == settle_len_q - 18'h1 ##1 wake_exec_o)
    else $error("settle wait length wrong");
  hiz_a: assert property (mode_q == PMC_STANDBY |-> port_hiz_o && !sys_osc_en_o)
    else $error("ports not released in standby");
  reset_pin_a: assert property (disable iff (!rst_b_i) mode_q == PMC_SLEEP && !ext_rst_sync_q
                                |=> mode_q == PMC_HIGH && cpu_reset_o)
    else $error("reset pin did not leave sleep");

endmodule

`default_nettype wire

// *** sim/pmc_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module pmc_far_model (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        raise_i,
  input  wire logic [4:0]  src_i,
  input  wire logic [7:0]  mode_i,
  output logic      [18:0] wake_req_o,
  output logic             sub_tick_o
);
  logic [7:0] mode_q;
  logic [2:0] div_q;

  // Requests stay as levels until the mode moves, like an unserviced flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_req_o <= '0;
      mode_q     <= 8'h01;
    end else begin
      mode_q <= mode_i;
      if (mode_i != mode_q) begin
        wake_req_o <= '0;
      end else if (raise_i) begin
        wake_req_o[src_i] <= 1'b1;
      end
    end
  end

  // Watch clock tick; the subclock oscillator never stops, so it runs free
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q      <= 3'h0;
      sub_tick_o <= 1'b0;
    end else begin
      div_q      <= div_q + 3'h1;
      sub_tick_o <= (div_q == 3'h7);
    end
  end
endmodule

`default_nettype wire

// *** sim/power_mode_controller_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module power_mode_controller_tb;
  import pmc_pkg::*;
  localparam logic [17:0] A1 = 18'(`PMC_CTRL_ONE_IDX * 4);
  localparam logic [17:0] A2 = 18'(`PMC_CTRL_TWO_IDX * 4);
  logic         clock_i, rst_b_i, psel, penable, pwrite, sleep, timer_a_clock_source_bit, imask, ext_n, raise;
  logic         pready, pslverr, subt, cpu_en, per_en, osc_en, noise, hiz, wexec, cpu_rst;
  logic [17:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [18:0]  wreq, wen;
  logic [4:0]   src, ign;
  pmc_mode_type mode;
  int           bad_count, check_count, m, m1, m2;

  pmc_top #(.SETTLE_CNT_0(18'd8), .SETTLE_CNT_1(18'd16), .SETTLE_CNT_2(18'd32),
    .SETTLE_CNT_3(18'd64), .SETTLE_CNT_4(18'd128)) uut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sleep_exec_i(sleep),
    .timer_a_clock_source_bit_i(timer_a_clock_source_bit), .irq_mask_i(imask), .wake_req_i(wreq),
    .wake_en_i(wen), .sub_tick_i(subt), .external_reset_n_i(ext_n), .mode_o(mode),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .sys_osc_en_o(osc_en),
    .noise_sample_en_o(noise), .port_hiz_o(hiz), .irq_ignore_o(ign),
    .wake_exec_o(wexec), .cpu_reset_o(cpu_rst));

  pmc_far_model far (.clock_i(clock_i), .rst_b_i(rst_b_i), .raise_i(raise), .src_i(src),
    .mode_i(mode), .wake_req_o(wreq), .sub_tick_o(subt));

  // Free running system clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Setup then access; request held until pready is seen high
  task automatic apb(input logic wr, input logic [17:0] a, input int d, output logic [31:0] r,
                     output logic e);
    tick();
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= 32'(d);
    tick();
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      tick();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mode decision taken from one snapshot of the control bits
  function automatic int dec(input int md, input int a, input int b, input int t);
    int s, l, d, ms;
    s = (a >> 7) & 1;
    l = (a >> 3) & 1;
    d = (b >> 3) & 1;
    ms = (b >> 2) & 1;
    if (md == 1 || md == 2) begin
      if (d && md == 1 && !s && ms && !l) return 2;
      if (d && md == 2 && !s && !ms && !l) return 1;
      if (d && s && t && l) return 4;
      if (!s && !l) return 8;
      if (s && t) return 32;
      if (s && !l) return 64;
      return md;
    end
    if (d && s && t && !l) return ms ? 2 : 1;
    if (s && t) return 32;
    if (!s) return 16;
    return md;
  endfunction

  // Write both registers, then read them back against the model
  task automatic regs(input int w1, input int w2);
    logic [31:0] r;
    logic        e;
    apb(1'b1, A1, w1, r, e);
    m1 = (w1 & 'hf8) | 'h07;
    apb(1'b1, A2, w2, r, e);
    m2 = (m == 4) ? ((w2 & 'h1c) | (m2 & 'h03) | 'he0) : ((w2 & 'h1f) | 'he0);
    apb(1'b0, A1, 0, r, e);
    `CHK(r, 32'(m1))
    apb(1'b0, A2, 0, r, e);
    `CHK(r, 32'(m2))
  endtask

  task automatic sleep_go(input int t);
    int em;
    tick();
    timer_a_clock_source_bit <= 1'(t);
    sleep <= 1'b1;
    tick();
    sleep <= 1'b0;
    em = dec(m, m1, m2, t);
    tick();
    `CHK(mode, 8'(em))
    m = em;
  endtask

  task automatic pin_reset();
    ext_n <= 1'b0;
    tick(4);
    `CHK(cpu_rst, 1'b1)
    ext_n <= 1'b1;
    tick(4);
    `CHK(mode, PMC_HIGH)
    m = 1;
    m1 = 'h07;
    m2 = 'he0;
  endtask

  // Spacing of noise pulses, or of cpu enables in subactive (watch tick is 8 clocks)
  task automatic gap_chk(input bit sub);
    int n;
    n = 0;
    while ((sub ? cpu_en : noise) !== 1'b1 && n < 80) begin
      tick();
      n++;
    end
    n = 0;
    do begin
      tick();
      n++;
    end while ((sub ? cpu_en : noise) !== 1'b1 && n < 80);
    if (sub) `CHK(n, (m2 & 2) ? 16 : ((m2 & 1) ? 32 : 64))
    else `CHK(n, (m2 & 'h10) ? 4 : 16)
  endtask

  // Blocked first by mask or enable, then woken
  task automatic wake(input int sel);
    int n, tgt, nset;
    tgt = (m2 & 4) ? 2 : 1;
    if (m == 8) `CHK(cpu_en, 1'b0)
    if (m == 8) `CHK(per_en, 1'b1)
    if (m == 64) `CHK(hiz, 1'b1)
    if (m >= 16) `CHK(osc_en, 1'b0)
    if (m == 64 || m == 32) `CHK(ign, (m == 64) ? 5'h1c : 5'h1e)
    if (sel & 1) imask <= 1'b1;
    else wen <= '0;
    raise <= 1'b1;
    src <= 5'(sel);
    tick();
    raise <= 1'b0;
    tick(4);
    `CHK(mode, 8'(m))
    imask <= 1'b0;
    wen <= '1;
    n = 0;
    while (mode === 8'(m) && n < 20) begin
      tick();
      n++;
    end
    if (m == 16 || (m == 32 && (m1 & 8))) tgt = 4;
    else if (m == 64 || m == 32) begin
      `CHK(osc_en, 1'b1)
      nset = (m1 & 'h40) ? 128 : 8 << ((m1 >> 4) & 3);
      n = 0;
      while (mode === PMC_SETTLE && n < 300) begin
        tick();
        n++;
      end
      `CHK(n, nset)
    end
    `CHK(mode, 8'(tgt))
    `CHK(wexec, 1'b1)
    m = tgt;
  endtask

  // Hang guard, sized well beyond the longest settle-heavy run
  initial begin
    tick(60000);
    bad_count++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    int          w1, w2, t, sd;
    {psel, penable, pwrite, sleep, timer_a_clock_source_bit, imask, raise} = '0;
    {paddr, pwdata, src} = '0;
    wen = '1;
    ext_n = 1'b1;
    rst_b_i = 1'b0;
    sd = $urandom(9);
    tick(8);
    rst_b_i <= 1'b1;
    apb(1'b0, A1, 0, r, e);
    `CHK(r, 32'h07)
    apb(1'b0, A2, 0, r, e);
    `CHK(r, 32'he0)
    apb(1'b1, 18'h00010, 'hff, r, e);
    `CHK(e, 1'b1)
    apb(1'b0, 18'h00010, 0, r, e);
    `CHK(r, 32'h0)
    $display("test registers done");
    for (int i = 0; i < 36; i++) begin
      pin_reset();
      // Reach medium or subactive first by direct transfer
      if (i % 3 == 1) regs('h00, 'h0c);
      if (i % 3 == 2) regs('h88, 'h08 | $urandom % 4);
      if (i % 3 != 0) sleep_go(i % 3 - 1);
      w1 = $urandom % 256;
      w2 = $urandom % 256;
      t = $urandom % 2;
      // Subactive keeps only combinations with a defined outcome
      if (m == 4) t = 1;
      if (m == 4 && !(w1 & 'h80)) w1 |= 8;
      regs(w1, w2);
      gap_chk(m == 4);
      sleep_go(t);
      if (m >= 8 && !(m == 8 && i % 4 == 0)) wake((m == 8) ? $urandom % 19 : 8 + $urandom % 8);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule

`default_nettype wire
